/* src/cic_fir_decimation_chain.sv */
`timescale 1ns/1ps
`default_nettype none

module fir_decim #(
   parameter int TAPS  = 32,
   parameter int LANES = 4
) (
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire dfilt_pkg::fir_cfg_t cfg_i,
   input  wire logic               cwe_i,
   input  wire logic [5:0]         cadr_i,
   input  wire logic [19:0]        cdat_i,
   input  wire dfilt_pkg::sample_t in_i,
   output dfilt_pkg::sample_t      out_o
);
   logic signed [19:0] coef [TAPS];
   logic signed [19:0] x    [TAPS];
   logic signed [26:0] gained;
   logic signed [26:0] rounded;
   logic signed [19:0] next_x;
   logic [2:0]         dcnt;
   logic               busy;
   logic [7:0]         idx;
   logic [7:0]         len;
   logic [7:0]         step;
   logic signed [dfilt_pkg::ACCW-1:0] acc;
   logic signed [dfilt_pkg::ACCW-1:0] next_acc;
   logic signed [dfilt_pkg::ACCW-1:0] scaled;
   logic               go;

   assign len  = {2'b00, cfg_i.len_m1};
   assign step = cfg_i.half_band ? 8'h02 : 8'h01;

   // Gain then round to 20 bits with saturation
   always_comb begin
      gained  = 27'($signed(in_i.data)) <<< cfg_i.gain;
      rounded = (gained + 27'sh8) >>> 4;
      if (rounded > 27'sh7ffff)
         next_x = 20'sh7ffff;
      else if (rounded < -27'sh80000)
         next_x = -20'sh80000;
      else
         next_x = rounded[19:0];
   end

   // Coefficient store, written by the host
   always_ff @(posedge clk_i) begin
      if (cwe_i && {2'b00, cadr_i} < 8'(TAPS))
         coef[cadr_i[$clog2(TAPS)-1:0]] <= cdat_i;
   end

   // Delay line; new sample enters at index zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < TAPS; i++)
            x[i] <= '0;
      end else if (in_i.valid) begin
         x[0] <= next_x;
         for (int i = 1; i < TAPS; i++)
            x[i] <= x[i-1];
      end
   end

   // Decimation counter picks the input that starts a computation
   always_ff @(posedge clk_i) begin
      if (rst_i)
         dcnt <= '0;
      else if (in_i.valid)
         dcnt <= (dcnt >= cfg_i.decim_m1) ? 3'h0 : dcnt + 3'h1;
   end
   assign go = in_i.valid && dcnt >= cfg_i.decim_m1;

   // One pass covers LANES taps; mirrored index in symmetric mode
   always_comb begin
      logic [7:0] p;
      logic [7:0] m;
      p = '0;
      m = '0;
      next_acc = acc;
      for (int j = 0; j < LANES; j++) begin
         p = idx + 8'(j) * step;
         m = (cfg_i.symmetric && p > (len >> 1)) ? len - p : p;
         if (p <= len && p < 8'(TAPS))
            next_acc = next_acc + dfilt_pkg::ACCW'(coef[m[$clog2(TAPS)-1:0]] * x[p[$clog2(TAPS)-1:0]]);
      end
   end

   // Multiply-accumulate sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy <= 1'b0;
         idx  <= '0;
         acc  <= '0;
      end else if (go) begin
         busy <= 1'b1;
         idx  <= '0;
         // Fixed centre tap of the half-band, weight 8 (HB_SH is three above OUT_SH)
         acc  <= cfg_i.half_band ? dfilt_pkg::ACCW'(next_x) <<< dfilt_pkg::HB_SH : '0;
      end else if (busy) begin
         acc  <= next_acc;
         idx  <= idx + 8'(LANES) * step;
         busy <= (idx + 8'(LANES) * step) <= len;
      end
   end

   // Centre sample for half-band is x[len/2] at start; caught above from
   // next_x only when len is zero or one; no pass corrects it, scaled is acc shifted.
   assign scaled = acc >>> dfilt_pkg::OUT_SH;

   // Saturated 24-bit output, one cycle after the last pass
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_o <= '0;
      end else begin
         out_o.valid <= busy && (idx + 8'(LANES) * step) > len;
         if (busy && (idx + 8'(LANES) * step) > len) begin
            if (next_acc >>> dfilt_pkg::OUT_SH > 48'sh7fffff)
               out_o.data <= 24'h7fffff;
            else if (next_acc >>> dfilt_pkg::OUT_SH < -48'sh800000)
               out_o.data <= 24'h800000;
            else
               out_o.data <= 24'(next_acc >>> dfilt_pkg::OUT_SH);
         end
      end
   end
endmodule // fir_decim

module cic_fir_decimation_chain (
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic [11:0]        wb_adr_i,
   input  wire logic [31:0]        wb_dat_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic               wb_we_i,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   output logic [31:0]             wb_dat_o,
   output logic                    wb_ack_o,
   input  wire dfilt_pkg::sample_t mix_i,
   input  wire logic [3:0]         in_exp_i,
   input  wire logic [2:0]         range_exp_i,
   output dfilt_pkg::sample_t      agc_o
);
   logic [31:0]         ctrl;
   logic [31:0]         filt;
   dfilt_pkg::fir_cfg_t first_fir_cfg;
   dfilt_pkg::fir_cfg_t second_fir_cfg;
   logic                wr;
   logic [7:0]          shift_tot;
   logic [68:0]         sh;
   logic                sh_v;
   logic [68:0]         integ [dfilt_pkg::NSTG];
   logic [68:0]         mask  [dfilt_pkg::NSTG];
   logic [23:0]         cprev [dfilt_pkg::NSTG];
   logic [23:0]         cs    [dfilt_pkg::NSTG+1];
   logic [2:0]          nst;
   logic [15:0]         rcnt;
   logic                dstb;
   logic                pass;
   dfilt_pkg::sample_t  cic;
   dfilt_pkg::sample_t  first_fir_out;
   logic [23:0]         last_out;

   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

   // Byte-lane merge for config writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
      for (int b = 0; b < 4; b++)
         if (sel[b])
            old[8*b +: 8] = d[8*b +: 8];
      return old;
   endfunction

   // Wishbone ack: one cycle after the strobe, dropped the next
   always_ff @(posedge clk_i) begin
      if (rst_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
   end

   // Configuration registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl     <= dfilt_pkg::CTRL_RST;
         filt     <= dfilt_pkg::FILT_RST;
         first_fir_cfg <= dfilt_pkg::FIR_RST;
         second_fir_cfg <= dfilt_pkg::FIR_RST;
      end else if (wr) begin
         case (wb_adr_i)
            dfilt_pkg::CTRL_OFS: ctrl     <= merge(ctrl, wb_dat_i, wb_sel_i);
            dfilt_pkg::FILT_OFS: filt     <= merge(filt, wb_dat_i, wb_sel_i);
            dfilt_pkg::FIRST_FIR_OFS: first_fir_cfg <= merge(first_fir_cfg, wb_dat_i, wb_sel_i);
            dfilt_pkg::SECOND_FIR_OFS: second_fir_cfg <= merge(second_fir_cfg, wb_dat_i, wb_sel_i);
            default: ;
         endcase
      end
   end

   // Read mux; coefficients and unmapped words read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= '0;
      end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
         case (wb_adr_i)
            dfilt_pkg::CTRL_OFS: wb_dat_o <= ctrl;
            dfilt_pkg::FILT_OFS: wb_dat_o <= filt;
            dfilt_pkg::FIRST_FIR_OFS: wb_dat_o <= first_fir_cfg;
            dfilt_pkg::SECOND_FIR_OFS: wb_dat_o <= second_fir_cfg;
            dfilt_pkg::STAT_OFS: wb_dat_o <= {8'h00, last_out};
            default:             wb_dat_o <= '0;
         endcase
      end
   end

   // Total shift: base code plus both exponents
   assign shift_tot = 8'(ctrl[dfilt_pkg::SHIFT_LSB +: 6]) + 8'(in_exp_i) + 8'(range_exp_i);

   // Sign-extended placement then left shift; lost MSBs are dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sh   <= '0;
         sh_v <= 1'b0;
      end else begin
         sh_v <= mix_i.valid;
         if (mix_i.valid)
            sh <= 69'($signed(mix_i.data)) << shift_tot;
      end
   end

   // Stage count clamps at five
   assign nst  = (filt[2:0] > 3'(dfilt_pkg::NSTG)) ? 3'(dfilt_pkg::NSTG) : filt[2:0];
   assign pass = filt[dfilt_pkg::BYPASS_BIT] || nst == 3'h0;

   // MSB-aligned pruning masks so each integrator wraps at its own width
   always_comb begin
      for (int k = 0; k < dfilt_pkg::NSTG; k++)
         mask[k] = {69{1'b1}} << (dfilt_pkg::CICW - dfilt_pkg::INT_W[k]);
   end

   // Integrators run on every input sample
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int k = 0; k < dfilt_pkg::NSTG; k++)
            integ[k] <= '0;
      end else if (sh_v) begin
         integ[0] <= integ[0] + sh;
         for (int k = 1; k < dfilt_pkg::NSTG; k++)
            integ[k] <= (integ[k] + (integ[k-1] & mask[k])) & mask[k];
      end
   end

   // Decimation counter; field holds R minus one
   always_ff @(posedge clk_i) begin
      if (rst_i)
         rcnt <= '0;
      else if (sh_v)
         rcnt <= (rcnt >= filt[dfilt_pkg::DEC_LSB +: 16]) ? 16'h0000 : rcnt + 16'h0001;
   end
   assign dstb = sh_v && rcnt >= filt[dfilt_pkg::DEC_LSB +: 16];

   // Comb chain; stages past the count pass straight through
   always_comb begin
      cs[0] = (nst == 3'h0) ? '0 : integ[nst - 3'h1][68:45];
      for (int k = 0; k < dfilt_pkg::NSTG; k++)
         cs[k+1] = (3'(k) < nst) ? cs[k] - cprev[k] : cs[k];
   end

   // Comb memory of one decimated sample
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int k = 0; k < dfilt_pkg::NSTG; k++)
            cprev[k] <= '0;
      end else if (dstb) begin
         for (int k = 0; k < dfilt_pkg::NSTG; k++)
            cprev[k] <= cs[k];
      end
   end

   // CIC output register, bypass runs at the input rate
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cic <= '0;
      end else if (pass) begin
         cic.valid <= sh_v;
         if (sh_v)
            cic.data <= sh[68:45];
      end else begin
         cic.valid <= dstb;
         if (dstb)
            cic.data <= cs[dfilt_pkg::NSTG];
      end
   end

   // First FIR, half-band capable
   fir_decim #(.TAPS(32), .LANES(dfilt_pkg::LANES1)) first_fir (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .cfg_i  (first_fir_cfg),
      .cwe_i  (wr && wb_adr_i[11:8] == dfilt_pkg::COEF1_OFS[11:8] && wb_sel_i == 4'hf),
      .cadr_i (wb_adr_i[7:2]),
      .cdat_i (wb_dat_i[19:0]),
      .in_i   (cic),
      .out_o  (first_fir_out)
   );

   // Second FIR; half-band bit is forced off
   fir_decim #(.TAPS(64), .LANES(dfilt_pkg::LANES2)) second_fir (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .cfg_i  ({second_fir_cfg[31:13], 1'b0, second_fir_cfg[11:0]}),
      .cwe_i  (wr && wb_adr_i[11:8] == dfilt_pkg::COEF2_OFS[11:8] && wb_sel_i == 4'hf),
      .cadr_i (wb_adr_i[7:2]),
      .cdat_i (wb_dat_i[19:0]),
      .in_i   (first_fir_out),
      .out_o  (agc_o)
   );

   // Last output kept for status reads
   always_ff @(posedge clk_i) begin
      if (rst_i)
         last_out <= '0;
      else if (agc_o.valid)
         last_out <= agc_o.data;
   end
endmodule // cic_fir_decimation_chain

`default_nettype wire

/* src/dfilt_pkg.sv */
package dfilt_pkg;
   // Sample widths, stage count and shifts
   localparam int SW      = 24;
   localparam int FW      = 20;
   localparam int CICW    = 69;
   localparam int NSTG    = 5;
   localparam int ACCW    = 48;
   localparam int PLACE   = 45;
   localparam int OUT_SH  = 15;
   localparam int HB_SH   = 18;
   localparam int INT_W [NSTG] = '{69, 62, 53, 44, 34};
   // Register byte offsets
   localparam logic [11:0] CTRL_OFS  = 12'h000;
   localparam logic [11:0] FILT_OFS  = 12'h004;
   localparam logic [11:0] FIRST_FIR_OFS  = 12'h008;
   localparam logic [11:0] SECOND_FIR_OFS  = 12'h00c;
   localparam logic [11:0] STAT_OFS  = 12'h010;
   localparam logic [11:0] COEF1_OFS = 12'h400;
   localparam logic [11:0] COEF2_OFS = 12'h800;
   // Field positions
   localparam int SHIFT_LSB  = 20;
   localparam int BYPASS_BIT = 15;
   localparam int DEC_LSB    = 16;
   // Reset values, tap counts and lane counts
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] FILT_RST = 32'h0000_8000;
   localparam logic [31:0] FIR_RST  = 32'h0000_0000;
   localparam logic [11:0] TAPS1    = 12'h020;
   localparam logic [11:0] TAPS2    = 12'h040;
   localparam int LANES1 = 4;
   localparam int LANES2 = 8;

   typedef struct packed {
      logic          valid;
      logic [SW-1:0] data;
   } sample_t;

   // Per-FIR configuration word layout
   typedef struct packed {
      logic [18:0] unused;
      logic        half_band;
      logic        symmetric;
      logic [1:0]  gain;
      logic [2:0]  decim_m1;
      logic [5:0]  len_m1;
   } fir_cfg_t;
endpackage

/* src/placeholder_none.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* tb/cic_fir_chain_props.sv */
`timescale 1ns/1ps
`default_nettype none
module cic_fir_chain_props (
   input wire logic               clk_i,
   input wire logic               rst_i,
   input wire logic [11:0]        wb_adr_i,
   input wire logic [31:0]        wb_dat_i,
   input wire logic [3:0]         wb_sel_i,
   input wire logic               wb_we_i,
   input wire logic               wb_cyc_i,
   input wire logic               wb_stb_i,
   input wire logic [31:0]        wb_dat_o,
   input wire logic               wb_ack_o,
   input wire dfilt_pkg::sample_t mix_i,
   input wire logic [3:0]         in_exp_i,
   input wire logic [2:0]         range_exp_i,
   input wire dfilt_pkg::sample_t agc_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [7:0] idle;
   logic       plain;
   // Age of newest sample, held at 255 so it never wraps
   always_ff @(posedge clk_i) begin
      if (rst_i || mix_i.valid) idle <= 8'h00;
      else if (idle != 8'hff) idle <= idle + 8'h01;
   end
   // Reset config gives one output per input; rate writes end that
   always_ff @(posedge clk_i) begin
      if (rst_i) plain <= 1'b1;
      else if (wb_ack_o && wb_we_i && wb_adr_i inside {dfilt_pkg::FILT_OFS, dfilt_pkg::FIRST_FIR_OFS,
                                                       dfilt_pkg::SECOND_FIR_OFS}) plain <= 1'b0;
   end
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
   property p_ack_taken; s_req |=> s_ack; endproperty
   a_ack_taken: assert property (p_ack_taken) else $error("ack not one cycle after request");
   property p_no_ack; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
   a_no_ack: assert property (p_no_ack) else $error("ack without request");
   property p_out_pulse; agc_o.valid |=> !agc_o.valid; endproperty
   a_out_pulse: assert property (p_out_pulse) else $error("output strobe too long");
   property p_out_hold; !agc_o.valid |-> $stable(agc_o.data); endproperty
   a_out_hold: assert property (p_out_hold) else $error("output changed without strobe");
   property p_out_cause; agc_o.valid |-> idle < 8'd80; endproperty
   a_out_cause: assert property (p_out_cause) else $error("output with no recent input");
   property p_plain_rate; plain && mix_i.valid |-> ##[3:40] agc_o.valid; endproperty
   a_plain_rate: assert property (p_plain_rate) else $error("bypass path lost a sample");
   property p_stat;
      wb_ack_o && !wb_we_i && wb_adr_i == dfilt_pkg::STAT_OFS && idle > 8'd60 |-> wb_dat_o[23:0] == agc_o.data;
   endproperty
   a_stat: assert property (p_stat) else $error("status differs from last output");
   property p_hole; wb_ack_o && !wb_we_i && wb_adr_i == 12'h014 |-> wb_dat_o == 32'h0; endproperty
   a_hole: assert property (p_hole) else $error("unmapped read not zero");
endmodule // cic_fir_chain_props
bind cic_fir_decimation_chain cic_fir_chain_props i_props (.clk_i(clk_i), .rst_i(rst_i),
   .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .mix_i(mix_i), .in_exp_i(in_exp_i), .range_exp_i(range_exp_i), .agc_o(agc_o));
`default_nettype wire

/* tb/mixer_source.sv */
`timescale 1ns/1ps
`default_nettype none
module mixer_source (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              en_i,
   input  wire logic [23:0]       dat_i,
   input  wire logic [3:0]        iexp_i,
   input  wire logic [2:0]        rexp_i,
   output var dfilt_pkg::sample_t mix_o,
   output logic [3:0]             in_exp_o,
   output logic [2:0]             range_exp_o
);
   logic [1:0] gap;
   // One strobe, then three idle cycles so each FIR can finish;
   // idle lines toggle so off-strobe sampling shows up
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gap <= 2'h0;
         mix_o <= '0;
         in_exp_o <= 4'h0;
         range_exp_o <= 3'h0;
      end else if (en_i && gap == 2'h0) begin
         gap <= 2'h3;
         mix_o <= {1'b1, dat_i};
         in_exp_o <= iexp_i;
         range_exp_o <= rexp_i;
      end else begin
         gap <= (gap == 2'h0) ? 2'h0 : gap - 2'h1;
         mix_o <= {1'b0, ~mix_o.data};
         in_exp_o <= ~in_exp_o;
         range_exp_o <= ~range_exp_o;
      end
   end
endmodule // mixer_source
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic               clk_i = 1'b0, rst_i = 1'b1, en = 1'b0;
   logic [11:0]        wb_adr_i = 12'h000;
   logic [31:0]        wb_dat_i = 32'h0, wb_dat_o, rd;
   logic               wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
   dfilt_pkg::sample_t mix_i, agc_o;
   logic [3:0]         in_exp_i, iexp = 4'h0;
   logic [2:0]         range_exp_i, rexp = 3'h0;
   logic [23:0]        dat = 24'h0, last;
   logic [1:0]         g1, g2;
   int                 n_mismatch = 0, n_tests = 0, seed = 17, b, outs, s1 = 0;
   always #5 clk_i = ~clk_i;
   mixer_source i_mixer_source (.clk_i(clk_i), .rst_i(rst_i), .en_i(en), .dat_i(dat), .iexp_i(iexp),
      .rexp_i(rexp), .mix_o(mix_i), .in_exp_o(in_exp_i), .range_exp_o(range_exp_i));
   cic_fir_decimation_chain i_cic_fir_decimation_chain (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_sel_i(4'hf), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mix_i(mix_i), .in_exp_i(in_exp_i),
      .range_exp_i(range_exp_i), .agc_o(agc_o));
   // Gain stage: shift, round, clamp to 20 bits
   function automatic logic [19:0] f_gain(input logic [23:0] v, input logic [1:0] g);
      logic signed [27:0] s;
      s = (($signed({{4{v[23]}}, v}) <<< g) + 28'sd8) >>> 4;
      if (s > 28'sd524287) return 20'h7ffff;
      if (s < -28'sd524288) return 20'h80000;
      return s[19:0];
   endfunction
   // Bypassed CIC; first FIR scales its gain-stage output by 2^s, second FIR is unity
   function automatic logic [23:0] f_chain(input logic [23:0] x, input int t, input int s,
                                           input logic [1:0] a, c);
      logic [68:0] w;
      logic [19:0] y;
      logic [23:0] v;
      w = {{45{x[23]}}, x} << t;
      y = f_gain(w[68:45], a);
      v = 24'($signed(y)) <<< s;
      y = f_gain(v, c);
      return {{4{y[19]}}, y};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Classic single Wishbone cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      for (k = 0; k < 40; k++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1) break;
      end
      if (k == 40) n_mismatch++;
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   // Send one sample and compare the chain output
   task automatic one(input int t);
      int k;
      en <= 1'b1;
      for (k = 0; k < 40 && mix_i.valid !== 1'b1; k++) @(posedge clk_i);
      if (k == 40) n_mismatch++;
      en <= 1'b0;
      for (k = 0; k < 100 && agc_o.valid !== 1'b1; k++) @(posedge clk_i);
      if (k == 100) n_mismatch++;
      last = f_chain(dat, t, s1, g1, g2);
      chk({8'h0, agc_o.data}, {8'h0, last});
   endtask
   // Count outputs for n inputs, then drain
   task automatic cnt(input int n);
      int ins;
      ins = 0;
      outs = 0;
      en <= 1'b1;
      for (int k = 0; k < 400 + 8 * n; k++) begin
         @(posedge clk_i);
         if (mix_i.valid === 1'b1) ins++;
         if (ins == n) en <= 1'b0;
         if (agc_o.valid === 1'b1) outs++;
      end
   endtask
   task automatic complete_run;
      $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Watchdog well beyond the expected run
   initial begin
      #400000;
      n_mismatch++;
      complete_run;
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1, dfilt_pkg::COEF1_OFS, 32'h0000_8000);
      wb(1, dfilt_pkg::COEF2_OFS, 32'h0000_8000);
      // Random shifts, exponents, gains and data; first four keep reset FIR config
      for (int i = 0; i < 40; i++) begin
         b = 38 + ($random(seed) & 7);
         g1 = (i < 4) ? 2'h0 : 2'($random(seed));
         g2 = (i < 4) ? 2'h0 : 2'($random(seed));
         wb(1, dfilt_pkg::CTRL_OFS, 32'(b) << 20);
         if (i >= 4) wb(1, dfilt_pkg::FIRST_FIR_OFS, {21'h0, g1, 9'h0});
         if (i >= 4) wb(1, dfilt_pkg::SECOND_FIR_OFS, {21'h0, g2, 9'h0});
         dat <= (i % 4 == 1) ? 24'h800000 : 24'($random(seed));
         iexp <= 4'($random(seed) & 1);
         rexp <= 3'($random(seed) & 1);
         @(posedge clk_i);
         one(b + int'(iexp) + int'(rexp));
      end
      repeat (70) @(posedge clk_i);
      wb(0, dfilt_pkg::STAT_OFS, 32'h0);
      chk({8'h0, rd[23:0]}, {8'h0, last});
      wb(1, dfilt_pkg::CTRL_OFS, 32'd45 << 20);
      // Every decimation ratio on each FIR
      for (int f = 0; f < 2; f++) begin
         for (int m = 1; m <= 8; m++) begin
            wb(1, dfilt_pkg::FIRST_FIR_OFS, f ? 32'h0 : 32'(m - 1) << 6);
            wb(1, dfilt_pkg::SECOND_FIR_OFS, f ? 32'(m - 1) << 6 : 32'h0);
            cnt(3 * m);
            chk(32'(outs), 32'd3);
         end
      end
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, dfilt_pkg::FILT_OFS, 32'h0);
      chk(rd, dfilt_pkg::FILT_RST);
      wb(0, 12'h014, 32'h0);
      chk(rd, 32'h0);
      // CIC stage counts 0 to 5 at R of 4, base shift per stage gain
      for (int n = 0; n <= 5; n++) begin
         wb(1, dfilt_pkg::CTRL_OFS, 32'(45 - 2 * n) << 20);
         wb(1, dfilt_pkg::FILT_OFS, 32'h0003_0000 | 32'(n));
         cnt(12);
         chk(32'(outs), n == 0 ? 32'd12 : 32'd3);
      end
      // Symmetric two taps with coef 1 zero: mirroring doubles a repeated sample
      wb(1, dfilt_pkg::FILT_OFS, 32'h0000_8000);
      wb(1, dfilt_pkg::CTRL_OFS, 32'd45 << 20);
      wb(1, dfilt_pkg::SECOND_FIR_OFS, 32'h0);
      wb(1, dfilt_pkg::COEF1_OFS + 12'h004, 32'h0);
      wb(1, dfilt_pkg::FIRST_FIR_OFS, 32'h0000_0801);
      g1 = 2'h0;
      g2 = 2'h0;
      s1 = 1;
      iexp <= 4'h0;
      rexp <= 3'h0;
      for (int i = 0; i < 4; i++) begin
         dat <= 24'($random(seed));
         @(posedge clk_i);
         cnt(1);
         chk(32'(outs), 32'd1);
         one(45);
      end
      // Zero padding tap leaves only the fixed weight-8 centre term
      wb(1, dfilt_pkg::COEF1_OFS, 32'h0);
      wb(1, dfilt_pkg::FIRST_FIR_OFS, 32'h0000_1000);
      s1 = 3;
      for (int i = 0; i < 4; i++) begin
         dat <= 24'($random(seed));
         @(posedge clk_i);
         one(45);
      end
      complete_run;
   end
endmodule // tb_top
`default_nettype wire
